// ---- dma_regs_pkg.sv ----
package dma_regs_pkg;

	// ****************************************************************
	// register map, byte addresses
	// ****************************************************************
	localparam logic [7:0]  RX_BASE_OFFSET   = 8'h18; // receive_list_base
	localparam logic [7:0]  TX_BASE_OFFSET   = 8'h20; // transmit_list_base
	localparam logic [7:0]  STATUS_OFFSET    = 8'h28; // host_status
	localparam logic [7:0]  MASK_OFFSET      = 8'h38; // interrupt mask
	localparam int          ADDR_W           = 8;     // byte address width
	localparam int          DATA_W           = 32;    // bus data width

	// ****************************************************************
	// field layout
	// ****************************************************************
	localparam int          FLAG_W           = 14;    // flags live in 13:0
	localparam int          ERR_LSB          = 23;    // error type 25:23
	localparam int          TX_STATE_LSB     = 20;    // transmit state 22:20
	localparam int          RX_STATE_LSB     = 17;    // receive state 19:17
	localparam int          NORMAL_SUM_BIT   = 16;    // normal summary
	localparam int          ABNORMAL_SUM_BIT = 15;    // abnormal summary
	localparam int          TX_DONE_BIT      = 0;     // transmit done
	localparam int          RX_STOPPED_BIT   = 8;     // receive stopped
	localparam int          EARLY_TX_BIT     = 10;    // early transmit
	localparam int          TIMER_BIT        = 11;    // timer expired
	localparam int          FATAL_BIT        = 13;    // fatal bus error
	localparam logic [13:0] FLAG_IMPL        = 14'h2FEF; // implemented flags
	localparam logic [13:0] NORMAL_GROUP     = 14'h0845; // bits 0,2,6,11
	localparam logic [13:0] ABNORMAL_GROUP   = 14'h27AA; // 1,3,5,7,8,9,10,13
	localparam logic [31:0] BASE_ALIGN_MASK  = 32'hFFFFFFFC; // longword align

	// ****************************************************************
	// reset values and codes
	// ****************************************************************
	localparam logic [31:0] BASE_RESET       = 32'h00000000; // list bases
	localparam logic [13:0] FLAG_RESET       = 14'h0000;     // flags
	localparam logic [13:0] MASK_RESET       = 14'h0000;     // all masked
	localparam logic [2:0]  STATE_STOPPED    = 3'h0;         // stopped code
	localparam logic [2:0]  ERR_RESET        = 3'h0;         // error type
	localparam logic [31:0] UNMAPPED_DATA    = 32'h00000000; // unmapped read

endpackage : dma_regs_pkg

// ---- reg_access_if.sv ----
`timescale 1ns/1ns
// ****************************************************************
// decoded register access between bus slave and register bank
// ****************************************************************
interface reg_access_if;
	logic        wr_stb; // write commits this edge
	logic        rd_stb; // read data captured this edge
	logic [7:0]  addr;   // byte address
	logic [31:0] wdata;  // write data
	logic [3:0]  be;     // byte enables
	logic [31:0] rdata;  // read data from bank

	modport bus_side (output wr_stb, rd_stb, addr, wdata, be, input rdata);
	modport reg_side (input wr_stb, rd_stb, addr, wdata, be, output rdata);
endinterface : reg_access_if

// ---- avalon_slave.sv ----
`timescale 1ns/1ns
// ****************************************************************
// avalon-mm slave, one wait state on every access
// ****************************************************************
module avalon_slave (
	input  wire logic        clk,             // system clock
	input  wire logic        rst_n,           // synchronised reset
	input  wire logic [7:0]  avs_address,     // byte address
	input  wire logic        avs_read,        // read request
	input  wire logic        avs_write,       // write request
	input  wire logic [31:0] avs_writedata,   // write data
	input  wire logic [3:0]  avs_byteenable,  // byte enables
	output logic      [31:0] avs_readdata,    // read data, registered
	output logic             avs_waitrequest, // stall, registered
	reg_access_if.bus_side   acc              // decoded access
);
	// waitrequest idles high so a request is always held one edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	// read data lands on the edge that drops waitrequest
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h00000000;
		end else if (acc.rd_stb) begin
			avs_readdata <= acc.rdata;
		end
	end

	assign acc.rd_stb = avs_read && avs_waitrequest;   // capture edge
	assign acc.wr_stb = avs_write && !avs_waitrequest; // master's sample edge
	assign acc.addr   = avs_address;
	assign acc.wdata  = avs_writedata;
	assign acc.be     = avs_byteenable;
endmodule : avalon_slave

// ---- status_flags.sv ----
`timescale 1ns/1ns
// ****************************************************************
// sticky event flags, set beats clear
// ****************************************************************
module status_flags (
	input  wire logic        clk,     // system clock
	input  wire logic        rst_n,   // synchronised reset
	input  wire logic [13:0] set_vec, // hardware events
	input  wire logic [13:0] clr_vec, // clears from software or hardware
	output logic      [13:0] flags    // sticky flags
);
	genvar i;
	generate
		for (i = 0; i < dma_regs_pkg::FLAG_W; i++) begin : g_flag
			// an event in the clear cycle is kept
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					flags[i] <= dma_regs_pkg::FLAG_RESET[i];
				end else if (set_vec[i]) begin
					flags[i] <= 1'b1;
				end else if (clr_vec[i]) begin
					flags[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule : status_flags

// ---- descriptor_base_and_status.sv ----
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
// ****************************************************************
// descriptor list bases and host status register
// ****************************************************************
module descriptor_base_and_status (
	input  wire logic        ref_clk,           // 25 MHz system clock
	input  wire logic        arst_n,            // async reset, active low
	input  wire logic [7:0]  avs_address,       // byte address
	input  wire logic        avs_read,          // read request
	input  wire logic        avs_write,         // write request
	input  wire logic [31:0] avs_writedata,     // write data
	input  wire logic [3:0]  avs_byteenable,    // byte enables
	output logic      [31:0] avs_readdata,      // read data
	output logic             avs_waitrequest,   // bus stall
	input  wire logic [13:0] event_pulse,       // per-flag event pulses
	input  wire logic        system_error,      // fatal bus error pulse
	input  wire logic [2:0]  system_error_type, // cause of system error
	input  wire logic [2:0]  transmit_state,    // transmit process state
	input  wire logic [2:0]  receive_state,     // receive process state
	output logic      [31:0] receive_list_base, // receive list start
	output logic      [31:0] transmit_list_base,// transmit list start
	output logic             bus_halt,          // stop all dma accesses
	output logic             irq                // interrupt request, level
);

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic        rst_meta_reg;   // first synchroniser stage
	logic        rst_sync_reg;   // released reset used everywhere

	// assert at once, release after two edges to avoid recovery hazards
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ****************************************************************
	// bus slave
	// ****************************************************************
	reg_access_if acc ();            // decoded register access

	avalon_slave u_slave (
		.clk             (ref_clk),
		.rst_n           (rst_sync_reg),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.acc             (acc)
	);

	// ****************************************************************
	// write decode
	// ****************************************************************
	logic [31:0] be_mask;        // byte enables spread to bits
	logic        wr_rx_base;     // write hits receive base
	logic        wr_tx_base;     // write hits transmit base
	logic        wr_status;      // write hits status
	logic        wr_mask;        // write hits mask

	// byte lanes expand to a 32-bit mask
	always_comb begin
		be_mask = {{8{acc.be[3]}}, {8{acc.be[2]}}, {8{acc.be[1]}}, {8{acc.be[0]}}};
	end

	// unmapped writes fall through every compare and are dropped
	assign wr_rx_base = acc.wr_stb && (acc.addr == dma_regs_pkg::RX_BASE_OFFSET);
	assign wr_tx_base = acc.wr_stb && (acc.addr == dma_regs_pkg::TX_BASE_OFFSET);
	assign wr_status  = acc.wr_stb && (acc.addr == dma_regs_pkg::STATUS_OFFSET);
	assign wr_mask    = acc.wr_stb && (acc.addr == dma_regs_pkg::MASK_OFFSET);

	// ****************************************************************
	// descriptor list base registers
	// ****************************************************************
	logic [31:0] rx_base_next;   // merged receive base
	logic [31:0] tx_base_next;   // merged transmit base

	// merge enabled lanes, then force longword alignment
	always_comb begin
		rx_base_next = (receive_list_base & ~be_mask) | (acc.wdata & be_mask);
		rx_base_next = rx_base_next & dma_regs_pkg::BASE_ALIGN_MASK;
		tx_base_next = (transmit_list_base & ~be_mask) | (acc.wdata & be_mask);
		tx_base_next = tx_base_next & dma_regs_pkg::BASE_ALIGN_MASK;
	end

	// receive base; writes land in any receive state, nothing gates them,
	// so software must write it only while receive is stopped
	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			receive_list_base <= dma_regs_pkg::BASE_RESET;
		end else if (wr_rx_base) begin
			receive_list_base <= rx_base_next;
		end
	end

	// transmit base, same handling as receive
	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			transmit_list_base <= dma_regs_pkg::BASE_RESET;
		end else if (wr_tx_base) begin
			transmit_list_base <= tx_base_next;
		end
	end

	// ****************************************************************
	// process state capture
	// ****************************************************************
	logic [2:0]  tx_state_reg;   // transmit state for readback
	logic [2:0]  rx_state_reg;   // receive state for readback

	// state fields are copies; the receive copy also feeds receive stopped detection
	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			tx_state_reg <= dma_regs_pkg::STATE_STOPPED;
			rx_state_reg <= dma_regs_pkg::STATE_STOPPED;
		end else begin
			tx_state_reg <= transmit_state;
			rx_state_reg <= receive_state;
		end
	end

	// ****************************************************************
	// receive stopped detection
	// ****************************************************************
	logic        rx_enter_stop;  // receive just entered stopped

	// previous value starts at stopped, so reset itself is no entry
	assign rx_enter_stop = (receive_state == dma_regs_pkg::STATE_STOPPED) &&
	                       (rx_state_reg != dma_regs_pkg::STATE_STOPPED);

	// ****************************************************************
	// fatal bus error handling
	// ****************************************************************
	logic [2:0]  err_type_reg;   // cause of last system error

	// cause is latched with the event and held until the next one
	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			err_type_reg <= dma_regs_pkg::ERR_RESET;
		end else if (system_error) begin
			err_type_reg <= system_error_type;
		end
	end

	// halt is sticky until reset: clearing the flag does not make the
	// bus safe again, software must reset the controller
	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			bus_halt <= 1'b0;
		end else if (system_error) begin
			bus_halt <= 1'b1;
		end
	end

	// ****************************************************************
	// event flags
	// ****************************************************************
	logic [13:0] flag_set;       // hardware sets
	logic [13:0] flag_clr;       // software and automatic clears
	logic [13:0] flags;          // sticky flags
	logic [13:0] w1c_bits;       // ones written to status

	// build set vector; only implemented positions can ever set
	always_comb begin
		flag_set = event_pulse & dma_regs_pkg::FLAG_IMPL;
		// timer expiry and fifo load come in on their own positions
		flag_set[dma_regs_pkg::TIMER_BIT]      = event_pulse[dma_regs_pkg::TIMER_BIT];
		flag_set[dma_regs_pkg::EARLY_TX_BIT]   = event_pulse[dma_regs_pkg::EARLY_TX_BIT];
		flag_set[dma_regs_pkg::RX_STOPPED_BIT] = rx_enter_stop;
		flag_set[dma_regs_pkg::FATAL_BIT]      = system_error;
	end

	// software clears with ones; transmit done clears early transmit
	always_comb begin
		w1c_bits = wr_status ? (acc.wdata[13:0] & be_mask[13:0]) : 14'h0000;
		flag_clr = w1c_bits;
		flag_clr[dma_regs_pkg::EARLY_TX_BIT] = w1c_bits[dma_regs_pkg::EARLY_TX_BIT] ||
		                                      flag_set[dma_regs_pkg::TX_DONE_BIT];
	end

	status_flags u_flags (
		.clk     (ref_clk),
		.rst_n   (rst_sync_reg),
		.set_vec (flag_set),
		.clr_vec (flag_clr),
		.flags   (flags)
	);

	// ****************************************************************
	// interrupt mask and summaries
	// ****************************************************************
	logic [13:0] mask_reg;       // one enables the flag
	logic [13:0] mask_next;      // merged mask write
	logic [13:0] live_flags;     // unmasked flags
	logic        normal_summary;  // normal group summary
	logic        abnormal_summary;// abnormal group summary

	// mask follows flag layout; unimplemented bits stay zero
	always_comb begin
		mask_next = (mask_reg & ~be_mask[13:0]) | (acc.wdata[13:0] & be_mask[13:0]);
		mask_next = mask_next & dma_regs_pkg::FLAG_IMPL;
	end

	// mask register
	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			mask_reg <= dma_regs_pkg::MASK_RESET;
		end else if (wr_mask) begin
			mask_reg <= mask_next;
		end
	end

	// summaries are pure functions of flags and mask, never stored,
	// so they can not go stale against the flags they report
	assign live_flags       = flags & mask_reg;
	assign normal_summary   = |(live_flags & dma_regs_pkg::NORMAL_GROUP);
	assign abnormal_summary = |(live_flags & dma_regs_pkg::ABNORMAL_GROUP);

	// request trails the summaries by one edge to come from a flop
	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			irq <= 1'b0;
		end else begin
			irq <= normal_summary || abnormal_summary;
		end
	end

	// ****************************************************************
	// read mux
	// ****************************************************************
	logic [31:0] status_word;    // assembled status register

	// status assembly; state and error fields are read only
	always_comb begin
		status_word = 32'h00000000;
		status_word[13:0] = flags & dma_regs_pkg::FLAG_IMPL;
		status_word[dma_regs_pkg::ABNORMAL_SUM_BIT] = abnormal_summary;
		status_word[dma_regs_pkg::NORMAL_SUM_BIT]   = normal_summary;
		status_word[dma_regs_pkg::RX_STATE_LSB +: 3] = rx_state_reg;
		status_word[dma_regs_pkg::TX_STATE_LSB +: 3] = tx_state_reg;
		status_word[dma_regs_pkg::ERR_LSB +: 3]      = err_type_reg;
	end

	// reads have no side effect on any flag
	always_comb begin
		unique case (acc.addr)
			dma_regs_pkg::RX_BASE_OFFSET: begin
				acc.rdata = receive_list_base;
			end
			dma_regs_pkg::TX_BASE_OFFSET: begin
				acc.rdata = transmit_list_base;
			end
			dma_regs_pkg::STATUS_OFFSET: begin
				acc.rdata = status_word;
			end
			dma_regs_pkg::MASK_OFFSET: begin
				acc.rdata = {18'h00000, mask_reg};
			end
			default: begin
				acc.rdata = dma_regs_pkg::UNMAPPED_DATA; // unmapped
			end
		endcase
	end

endmodule : descriptor_base_and_status

// ---- descriptor_base_and_status_monitor.sv ----
`timescale 1ns/1ns
// ********************
// port checker for list bases and host status
// ********************
module descriptor_base_and_status_monitor (
	input wire logic        ref_clk,            // system clock
	input wire logic        arst_n,             // async reset, active low
	input wire logic [7:0]  avs_address,        // byte address
	input wire logic        avs_read,           // read request
	input wire logic        avs_write,          // write request
	input wire logic [31:0] avs_writedata,      // write data
	input wire logic [3:0]  avs_byteenable,     // byte enables
	input wire logic [31:0] avs_readdata,       // read data
	input wire logic        avs_waitrequest,    // bus stall
	input wire logic [13:0] event_pulse,        // event pulses
	input wire logic        system_error,       // fatal error pulse
	input wire logic [2:0]  system_error_type,  // error cause
	input wire logic [2:0]  transmit_state,     // transmit state
	input wire logic [2:0]  receive_state,      // receive state
	input wire logic [31:0] receive_list_base,  // receive list start
	input wire logic [31:0] transmit_list_base, // transmit list start
	input wire logic        bus_halt,           // dma halted
	input wire logic        irq                 // interrupt request
);
	// ********************
	// completed accesses
	// ********************
	wire logic rd_done = avs_read && !avs_waitrequest;  // read data taken here
	wire logic wr_done = avs_write && !avs_waitrequest; // write commits here
	wire logic st_rd   = rd_done && avs_address == dma_regs_pkg::STATUS_OFFSET; // status read
	wire logic full_be = avs_byteenable == 4'hF;        // whole word written

	// one clock domain, so defaults keep each property short
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	// ********************
	// assertions
	// ********************
	a_rx_base_load: assert property (wr_done && full_be && avs_address == dma_regs_pkg::RX_BASE_OFFSET
		|=> receive_list_base == ($past(avs_writedata) & 32'hFFFFFFFC)) else $error("receive base load wrong");
	a_tx_base_load: assert property (wr_done && full_be && avs_address == dma_regs_pkg::TX_BASE_OFFSET
		|=> transmit_list_base == ($past(avs_writedata) & 32'hFFFFFFFC)) else $error("transmit base load wrong");
	a_base_aligned: assert property (receive_list_base[1:0] == 2'h0 && transmit_list_base[1:0] == 2'h0)
		else $error("list base not longword aligned");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait");
	a_halt_on_error: assert property (system_error |=> bus_halt)
		else $error("bus not halted after system error");
	a_halt_sticky: assert property (bus_halt |=> bus_halt)
		else $error("bus halt released");
	a_irq_summary: assert property (st_rd |-> irq == (avs_readdata[16] | avs_readdata[15]))
		else $error("irq disagrees with summaries");
	a_state_fields: assert property (st_rd |-> avs_readdata[22:17] ==
		{$past(transmit_state, 2), $past(receive_state, 2)}) else $error("state field wrong");
	a_error_quiet: assert property (st_rd && !bus_halt |-> avs_readdata[13] == 1'b0
		&& avs_readdata[25:23] == 3'h0) else $error("fatal flag without halt");

	// ********************
	// covers
	// ********************
	c_write: cover property (wr_done && full_be);
	c_irq_read: cover property (st_rd && irq);
	c_halt: cover property ($rose(bus_halt));
endmodule : descriptor_base_and_status_monitor

bind descriptor_base_and_status descriptor_base_and_status_monitor descriptor_base_and_status_monitor_i (
	.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .event_pulse(event_pulse),
	.system_error(system_error), .system_error_type(system_error_type),
	.transmit_state(transmit_state), .receive_state(receive_state),
	.receive_list_base(receive_list_base), .transmit_list_base(transmit_list_base),
	.bus_halt(bus_halt), .irq(irq));

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
	// ********************
	// stimulus and model state
	// ********************
	logic        ref_clk = 1'b0;             // 25 MHz clock
	logic        arst_n = 1'b0;              // reset, active low
	logic [7:0]  avs_address = 8'h00;        // bus address
	logic        avs_read = 1'b0;            // bus read
	logic        avs_write = 1'b0;           // bus write
	logic [31:0] avs_writedata = 32'h0;      // bus write data
	logic [3:0]  avs_byteenable = 4'h0;      // bus lanes
	logic [31:0] avs_readdata;               // bus read data
	logic        avs_waitrequest;            // bus stall
	logic [13:0] event_pulse = 14'h0;        // event pulses
	logic        system_error = 1'b0;        // fatal pulse
	logic [2:0]  system_error_type = 3'h0;   // fatal cause
	logic [2:0]  transmit_state = 3'h0;      // transmit state
	logic [2:0]  receive_state = 3'h0;       // receive state
	logic [31:0] receive_list_base;          // receive base out
	logic [31:0] transmit_list_base;         // transmit base out
	logic        bus_halt;                   // halt out
	logic        irq;                        // interrupt out
	int          error_cnt = 0;              // mismatches
	int          comparisons = 0;            // compares made
	int          cyc = 0;                    // cycle count for timeout
	logic [31:0] seed = 32'h0000B08B;        // xorshift state, starts at 45195
	logic [13:0] flag_m = 14'h0;             // expected flags
	logic [13:0] mask_m = 14'h0;             // expected mask
	logic [2:0]  err_m = 3'h0;               // expected error type
	logic [2:0]  ts_m = 3'h0;                // expected transmit state
	logic [2:0]  rs_m = 3'h0;                // expected receive state
	logic [31:0] base_m [2];                 // expected bases
	logic [31:0] q;                          // last read data
	logic [31:0] r;                          // random word
	logic [7:0]  a;                          // chosen address

	always #20 ref_clk = ~ref_clk;

	descriptor_base_and_status descriptor_base_and_status_i (
		.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.event_pulse(event_pulse), .system_error(system_error),
		.system_error_type(system_error_type), .transmit_state(transmit_state),
		.receive_state(receive_state), .receive_list_base(receive_list_base),
		.transmit_list_base(transmit_list_base), .bus_halt(bus_halt), .irq(irq));

	// ********************
	// helpers
	// ********************
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// expected host status word from the model
	function logic [31:0] stat();
		logic [13:0] u;
		u = flag_m & mask_m;
		return {6'h00, err_m, ts_m, rs_m, |(u & 14'h0845), |(u & 14'h27AA), 1'b0, flag_m};
	endfunction : stat

	// lane merge; low bits always read back zero
	function logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d, input logic [3:0] b);
		for (int k = 0; k < 4; k++)
			if (b[k]) o[8*k +: 8] = d[8*k +: 8];
		return o & 32'hFFFFFFFC;
	endfunction : mrg

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task close_out();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out

	// one bus access: hold until waitrequest is sampled low, then release
	task acc(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] b);
		avs_write <= w;
		avs_read <= ~w;
		avs_address <= ad;
		avs_writedata <= d;
		avs_byteenable <= b;
		// no assumed latency: only the cycle guard below ends a hung wait
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask : acc

	task rd_chk(input logic [7:0] ad, input logic [31:0] exp);
		acc(1'b0, ad, 32'h0, 4'hF);
		chk(q, exp);
	endtask : rd_chk

	// single-cycle event pulse, model follows the early transmit clear
	task ev(input logic [13:0] p);
		event_pulse <= p;
		@(posedge ref_clk);
		event_pulse <= 14'h0000;
		if (p[0] && !p[10]) flag_m[10] = 1'b0;
		flag_m = flag_m | (p & 14'h0EEF);
		@(posedge ref_clk);
	endtask : ev

	task states(input logic [2:0] t, input logic [2:0] rs);
		transmit_state <= t;
		receive_state <= rs;
		if (rs_m != 3'h0 && rs == 3'h0) flag_m[8] = 1'b1;
		ts_m = t;
		rs_m = rs;
		repeat (3) @(posedge ref_clk);
	endtask : states

	// hang guard, far beyond the roughly 650 cycles the run needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 8000) begin
			error_cnt++;
			close_out();
		end
	end

	// ********************
	// main sequence
	// ********************
	initial begin
		base_m[0] = 32'h0;
		base_m[1] = 32'h0;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		// reset values, unmapped place reads zero and ignores writes
		acc(1'b1, 8'h30, 32'hFFFFFFFF, 4'hF);
		rd_chk(8'h30, 32'h0);
		rd_chk(dma_regs_pkg::RX_BASE_OFFSET, 32'h0);
		rd_chk(dma_regs_pkg::TX_BASE_OFFSET, 32'h0);
		rd_chk(dma_regs_pkg::MASK_OFFSET, 32'h0);
		rd_chk(dma_regs_pkg::STATUS_OFFSET, stat());
		// bases loaded while both processes stay stopped, before any start
		for (int i = 0; i < 10; i++) begin
			r = rnd();
			a = i[0] ? dma_regs_pkg::TX_BASE_OFFSET : dma_regs_pkg::RX_BASE_OFFSET;
			if (i < 4) r[1:0] = 2'h0;
			acc(1'b1, a, r, (i < 4) ? 4'hF : r[7:4]);
			base_m[i % 2] = mrg(base_m[i % 2], r, (i < 4) ? 4'hF : r[7:4]);
			rd_chk(a, base_m[i % 2]);
			chk(i[0] ? transmit_list_base : receive_list_base, base_m[i % 2]);
		end
		// early transmit set, cleared by transmit done unless both together
		acc(1'b1, dma_regs_pkg::MASK_OFFSET, 32'h00003FFF, 4'hF);
		mask_m = 14'h2FEF;
		ev(14'h0400);
		rd_chk(dma_regs_pkg::STATUS_OFFSET, stat());
		ev(14'h0001);
		rd_chk(dma_regs_pkg::STATUS_OFFSET, stat());
		ev(14'h0401);
		rd_chk(dma_regs_pkg::STATUS_OFFSET, stat());
		rd_chk(dma_regs_pkg::STATUS_OFFSET, stat());
		// random masks, states, events and one-to-clear writes
		for (int i = 0; i < 30; i++) begin
			r = rnd();
			acc(1'b1, dma_regs_pkg::MASK_OFFSET, {18'h0, r[13:0]}, 4'hF);
			mask_m = r[13:0] & 14'h2FEF;
			states(r[16:14], (i % 3 == 2) ? 3'h0 : r[19:17]);
			r = rnd();
			ev(r[13:0]);
			rd_chk(dma_regs_pkg::STATUS_OFFSET, stat());
			chk(irq, |(flag_m & mask_m));
			r = rnd();
			acc(1'b1, dma_regs_pkg::STATUS_OFFSET, r, 4'hF);
			flag_m = flag_m & ~r[13:0];
			rd_chk(dma_regs_pkg::STATUS_OFFSET, stat());
			chk(irq, |(flag_m & mask_m));
		end
		// fatal error: flag, cause, halt; clearing the flag keeps the halt
		acc(1'b1, dma_regs_pkg::STATUS_OFFSET, 32'h00003FFF, 4'hF);
		flag_m = 14'h0;
		// fatal flag unmasked, so the request must follow it
		acc(1'b1, dma_regs_pkg::MASK_OFFSET, 32'h00003FFF, 4'hF);
		mask_m = 14'h2FEF;
		r = rnd();
		system_error_type <= r[2:0] | 3'h4;
		system_error <= 1'b1;
		@(posedge ref_clk);
		system_error <= 1'b0;
		err_m = r[2:0] | 3'h4;
		flag_m[13] = 1'b1;
		repeat (2) @(posedge ref_clk);
		chk(bus_halt, 1'b1);
		rd_chk(dma_regs_pkg::STATUS_OFFSET, stat());
		chk(irq, 1'b1);
		acc(1'b1, dma_regs_pkg::STATUS_OFFSET, 32'h00002000, 4'hF);
		flag_m[13] = 1'b0;
		rd_chk(dma_regs_pkg::STATUS_OFFSET, stat());
		chk(bus_halt, 1'b1);
		chk(irq, 1'b0);
		close_out();
	end
endmodule : tb
